// >>> ccrg_pkg.sv
// Package: constants and carriers for the processor clock and reset generator
package ccrg_pkg;
  localparam int unsigned MASTER_HZ        = 20_000_000;
  localparam int unsigned CPU_DIV          = 6;
  localparam logic [2:0]  CPU_DIV_LAST     = 3'h5;
  localparam logic [2:0]  CPU_DIV_HALF     = 3'h3;
  localparam int unsigned POR_TIME_MS      = 2;
  localparam int unsigned POR_CYCLES       = (MASTER_HZ / 1000) * POR_TIME_MS;
  localparam int unsigned REL_TIME_US      = 1000;
  localparam int unsigned REL_CYCLES       = (MASTER_HZ / 1_000_000) * REL_TIME_US;
  localparam int unsigned DEB_TIME_US      = 200;
  localparam int unsigned DEB_CYCLES       = (MASTER_HZ / 1_000_000) * DEB_TIME_US;
  localparam int unsigned TMR_W            = 24;

  typedef struct packed {
    logic cpu_reset_n;
    logic nmi_n;
    logic system_reset_out_n;
  } ccrg_resets_t;

  typedef struct packed {
    logic master_to_cpu_div;
    logic master_to_video_div;
    logic master_to_video_proc;
  } ccrg_clk_fan_t;
endpackage

// >>> ccrg_timer.sv
// One-shot down counter used by the reset timers
`timescale 1ns/10ps
module ccrg_timer
  import ccrg_pkg::*;
#(
  parameter int unsigned CYCLES = 16
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Control
  input  wire logic restart,
  output logic      expired
);
  logic [TMR_W-1:0] count_reg;

  // Restart reloads; count runs down and parks at zero
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      count_reg <= '0;
    else if (restart)
      count_reg <= TMR_W'(CYCLES - 1);
    else if (count_reg != '0)
      count_reg <= count_reg - 1'b1;
  end

  assign expired = (count_reg == '0) && !restart;
endmodule

// >>> ccrg_divider.sv
// Divide-by-six processor clock counter with dual clear
`timescale 1ns/10ps
module ccrg_divider
  import ccrg_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Clear inputs, active high
  input  wire logic clear_a,
  input  wire logic clear_b,
  // Output
  output logic      cpu_clk_out
);
  logic [2:0] count_reg;
  logic       held;

  assign held = clear_a & clear_b;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      count_reg <= 3'h0;
    else if (held)
      count_reg <= 3'h0;
    else if (count_reg == CPU_DIV_LAST)
      count_reg <= 3'h0;
    else
      count_reg <= count_reg + 3'h1;
  end

  // Registered so the processor clock is glitch free
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      cpu_clk_out <= 1'b0;
    else if (held)
      cpu_clk_out <= 1'b0;
    else
      cpu_clk_out <= (count_reg >= CPU_DIV_HALF) ? 1'b0 : 1'b1;
  end
endmodule

// >>> ccrg_top.sv
// Processor clock and reset generator top level
`timescale 1ns/10ps
module ccrg_top
  import ccrg_pkg::*;
(
  // Clock and power-up reset
  input  wire logic    clock,
  input  wire logic    reset,
  // Factory test, active low
  input  wire logic    factory_test_n,
  // Pushbutton, active low when pressed
  input  wire logic    restart_pushbutton,
  // Processor halt status, active low
  input  wire logic    cpu_halt_n,
  // Clock outputs
  output ccrg_clk_fan_t clk_fan,
  output logic          cpu_clk,
  // Reset outputs
  output ccrg_resets_t  resets
);
  logic btn_meta_reg;
  logic btn_sync_reg;
  logic btn_stable_reg;
  logic btn_prev_reg;
  logic [TMR_W-1:0] deb_reg;
  logic por_start_reg;
  logic por_expired;
  logic rel_expired;
  logic rel_restart;
  logic pressed;
  logic nmi_active_reg;
  logic halt_latched_reg;
  logic por_active;

  // Master clock fan-out to the three consumers
  assign clk_fan.master_to_cpu_div    = clock;
  assign clk_fan.master_to_video_div  = clock;
  assign clk_fan.master_to_video_proc = clock;

  // Second clear is the inverted test line: idle high keeps it low
  ccrg_divider u_cpu_clock_divider (
    .clock       (clock),
    .reset       (reset),
    .clear_a     (1'b1),
    .clear_b     (!factory_test_n),
    .cpu_clk_out (cpu_clk)
  );

  // Power-on timer starts once, on the first edge after reset
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      por_start_reg <= 1'b1;
    else
      por_start_reg <= 1'b0;
  end

  ccrg_timer #(.CYCLES(POR_CYCLES)) u_power_on_timer (
    .clock   (clock),
    .reset   (reset),
    .restart (por_start_reg),
    .expired (por_expired)
  );

  assign por_active = !por_expired;

  // Two-flop synchroniser; only the second stage is examined
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      btn_meta_reg <= 1'b1;
      btn_sync_reg <= 1'b1;
    end
    else
    begin
      btn_meta_reg <= restart_pushbutton;
      btn_sync_reg <= btn_meta_reg;
    end
  end

  // Debounce: accept a level only after it is steady
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      deb_reg        <= '0;
      btn_stable_reg <= 1'b1;
    end
    else if (btn_sync_reg == btn_stable_reg)
      deb_reg <= '0;
    else if (deb_reg == TMR_W'(DEB_CYCLES - 1))
    begin
      deb_reg        <= '0;
      btn_stable_reg <= btn_sync_reg;
    end
    else
      deb_reg <= deb_reg + 1'b1;
  end

  assign pressed = !btn_stable_reg;

  // Timer is held reloaded while pressed, runs after release
  assign rel_restart = pressed;

  ccrg_timer #(.CYCLES(REL_CYCLES)) u_button_release_timer (
    .clock   (clock),
    .reset   (reset),
    .restart (rel_restart),
    .expired (rel_expired)
  );

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      btn_prev_reg <= 1'b1;
    else
      btn_prev_reg <= btn_stable_reg;
  end

  // Halt latches the restart network until the next power-up
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      halt_latched_reg <= 1'b0;
    else if (!cpu_halt_n && !por_active)
      halt_latched_reg <= 1'b1;
  end

  // Restart active from press until release timer expires
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      nmi_active_reg <= 1'b0;
    else if (halt_latched_reg || por_active)
      nmi_active_reg <= 1'b0;
    else if (pressed)
      nmi_active_reg <= 1'b1;
    else if (rel_expired)
      nmi_active_reg <= 1'b0;
  end

  // Reset outputs, registered
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      resets <= '0;
    else
    begin
      resets.cpu_reset_n        <= !por_active;
      resets.nmi_n              <= !nmi_active_reg;
      resets.system_reset_out_n <= !(por_active || nmi_active_reg);
    end
  end

  // Assertions
  AST_POR_HOLDS: assert property (@(posedge clock) disable iff (reset)
    por_active |=> !resets.cpu_reset_n)
    else $error("Processor reset released during power-on interval");
  AST_POR_STAYS: assert property (@(posedge clock) disable iff (reset)
    resets.cpu_reset_n |=> resets.cpu_reset_n)
    else $error("Processor reset reasserted after release");
  AST_NMI_PRESS: assert property (@(posedge clock) disable iff (reset)
    (pressed && !halt_latched_reg && !por_active) |=> ##1 !resets.nmi_n)
    else $error("Restart not driven low while button pressed");
  AST_NMI_HOLD: assert property (@(posedge clock) disable iff (reset)
    ($fell(pressed) && nmi_active_reg && !halt_latched_reg) |=> !resets.nmi_n [*8])
    else $error("Restart released before release timer");
  AST_SYSTEM_RESET_OUT_N: assert property (@(posedge clock) disable iff (reset)
    resets.system_reset_out_n == (resets.cpu_reset_n && resets.nmi_n))
    else $error("System reset out does not follow reset sources");
  AST_HALT_LOCK: assert property (@(posedge clock) disable iff (reset)
    halt_latched_reg |=> ##1 resets.nmi_n)
    else $error("Button restart acted while halted");
  AST_DIV_CLEAR: assert property (@(posedge clock) disable iff (reset)
    !factory_test_n |=> !cpu_clk)
    else $error("Divider not cleared under test");
  AST_DIV_SIX: assert property (@(posedge clock) disable iff (reset)
    (factory_test_n [*8] ##0 $rose(cpu_clk) ##1 factory_test_n [*6]) |-> $rose(cpu_clk))
    else $error("Processor clock period is not six master cycles");
  AST_SYNC_STAGE: assert property (@(posedge clock) disable iff (reset)
    ##1 btn_sync_reg == $past(btn_meta_reg))
    else $error("Synchroniser second stage mismatch");
  // Falling edge, where every fanned copy must read high
  AST_FAN: assert property (@(negedge clock) disable iff (reset)
    clk_fan == 3'h7)
    else $error("Master clock fan-out broken");
  AST_HALT_SRC: assert property (@(posedge clock) disable iff (reset)
    (cpu_halt_n && !halt_latched_reg && !por_active) |=> !halt_latched_reg)
    else $error("Halt latched without halt input");

  COV_POR_DONE: cover property (@(posedge clock) disable iff (reset)
    $rose(resets.cpu_reset_n));
  COV_NMI: cover property (@(posedge clock) disable iff (reset)
    $fell(resets.nmi_n));
  COV_NMI_END: cover property (@(posedge clock) disable iff (reset)
    $rose(resets.nmi_n));
  COV_HALT: cover property (@(posedge clock) disable iff (reset)
    $rose(halt_latched_reg));

  // Release marker keeps button edge state observable
  COV_RELEASE: cover property (@(posedge clock) disable iff (reset)
    !btn_prev_reg && btn_stable_reg);
endmodule

// >>> ccrg_cpu_model.sv
// Behavioural processor core fed by the clock and reset generator
`timescale 1ns/10ps
module ccrg_cpu_model
  import ccrg_pkg::*;
(
  // From the generator
  input  wire logic   cpu_clk,
  input  wire logic   cpu_reset_n,
  input  wire logic   nmi_n,
  // Scenario command
  input  wire logic   halt_cmd,
  // Core status
  output logic        halt_n,
  output logic [15:0] pc
);
  // Halt shows only when a halt is executed
  assign halt_n = ~halt_cmd;
  always_ff @(posedge cpu_clk or negedge cpu_reset_n)
  begin
    if (!cpu_reset_n)
      pc <= 16'h0000;
    else if (!nmi_n)
      pc <= 16'h0066;
    else if (!halt_cmd)
      pc <= pc + 16'h0001;
  end
endmodule

// >>> ccrg_top_tb_top.sv
// Self-checking bench for the processor clock and reset generator
`timescale 1ns/10ps
module ccrg_top_tb_top
  import ccrg_pkg::*;
;
  localparam int LIMIT = 90000;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  logic          factory_test_n = 1'b1;
  logic          restart_pushbutton = 1'b1;
  logic          halt_cmd = 1'b0;
  logic          cpu_halt_n;
  logic          cpu_clk;
  logic [15:0]   pc;
  ccrg_clk_fan_t clk_fan;
  ccrg_resets_t  resets;
  int            n_fail = 0;
  int            n_tests = 0;
  int            cyc = 0;
  ccrg_top dut_u (.clock(clock), .reset(reset), .factory_test_n(factory_test_n),
    .restart_pushbutton(restart_pushbutton), .cpu_halt_n(cpu_halt_n),
    .clk_fan(clk_fan), .cpu_clk(cpu_clk), .resets(resets));
  ccrg_cpu_model cpu_u (.cpu_clk(cpu_clk), .cpu_reset_n(resets.cpu_reset_n),
    .nmi_n(resets.nmi_n), .halt_cmd(halt_cmd), .halt_n(cpu_halt_n), .pc(pc));
  initial
  begin
    forever #25 clock = ~clock;
  end
  function automatic logic [15:0] b16(input logic x);
    return {15'h0000, x};
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait on one reset output bit
  task automatic wait_bit(input int b, input logic v, input int lim);
    int k;
    k = 0;
    while (resets[b] !== v && k < lim)
    begin
      @(negedge clock);
      k++;
    end
    chk("reset bit", b16(v), b16(resets[b]));
  endtask
  task automatic t_por();
    repeat (POR_CYCLES - 20) @(negedge clock);
    chk("cpu reset", 16'h0000, b16(resets.cpu_reset_n));
    chk("sys reset", 16'h0000, b16(resets.system_reset_out_n));
    chk("start pc", 16'h0000, pc);
    wait_bit(2, 1'b1, 40);
    repeat (100) @(negedge clock);
    chk("cpu reset", 16'h0001, b16(resets.cpu_reset_n));
    chk("sys reset", 16'h0001, b16(resets.system_reset_out_n));
  endtask
  task automatic t_clk();
    int hi;
    int rises;
    logic prev;
    hi = 0;
    rises = 0;
    prev = cpu_clk;
    repeat (60)
    begin
      #5 chk("fan low", 16'h0000, {13'h0000, clk_fan});
      @(posedge clock);
      #5 chk("fan high", 16'h0007, {13'h0000, clk_fan});
      @(negedge clock);
      hi += cpu_clk;
      rises += (cpu_clk && !prev);
      prev = cpu_clk;
    end
    chk("clk high", 16'h001E, hi[15:0]);
    chk("clk rises", 16'h000A, rises[15:0]);
  endtask
  task automatic t_test();
    int hi;
    hi = 0;
    factory_test_n = 1'b0;
    @(negedge clock);
    repeat (24)
    begin
      @(negedge clock);
      hi += cpu_clk;
    end
    chk("cleared clk", 16'h0000, hi[15:0]);
    factory_test_n = 1'b1;
    repeat (24)
    begin
      @(negedge clock);
      hi += cpu_clk;
    end
    chk("running clk", 16'h000C, hi[15:0]);
  endtask
  task automatic t_button();
    restart_pushbutton = 1'b0;
    repeat (DEB_CYCLES - 10) @(negedge clock);
    chk("early restart", 16'h0001, b16(resets.nmi_n));
    wait_bit(1, 1'b0, 40);
    chk("sys reset", 16'h0000, b16(resets.system_reset_out_n));
    chk("cpu reset", 16'h0001, b16(resets.cpu_reset_n));
    repeat (20) @(negedge clock);
    chk("vector pc", 16'h0066, pc);
    restart_pushbutton = 1'b1;
    repeat (DEB_CYCLES + REL_CYCLES - 10) @(negedge clock);
    chk("restart held", 16'h0000, b16(resets.nmi_n));
    wait_bit(1, 1'b1, 40);
    chk("sys reset", 16'h0001, b16(resets.system_reset_out_n));
    repeat (12) @(negedge clock);
    chk("resume pc", 16'h0006, {4'h0, pc[15:4]});
  endtask
  task automatic t_halt();
    halt_cmd = 1'b1;
    repeat (12) @(negedge clock);
    restart_pushbutton = 1'b0;
    repeat (DEB_CYCLES + 100) @(negedge clock);
    chk("locked restart", 16'h0001, b16(resets.nmi_n));
    chk("locked sys", 16'h0001, b16(resets.system_reset_out_n));
    restart_pushbutton = 1'b1;
  endtask
  // Hang guard sized above the power-on interval plus the button walk
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_fail++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (8) @(negedge clock);
    chk("reset outs", 16'h0000, {12'h000, cpu_clk, resets});
    reset = 1'b0;
    t_por();
    t_clk();
    t_test();
    t_button();
    t_halt();
    wrap_up();
  end
endmodule
